/* src/hrap_pkg.sv */
// Constants and types shared by the host register access port.
// Assumes a 100 MHz system clock and a single asynchronous reset.
package hrap_pkg;
	// ==========================================================
	// Timing
	localparam int CLK_NS      = 10;
	localparam int RST_MIN_NS  = 10000;
	localparam int RST_MIN_CYC = (RST_MIN_NS + CLK_NS - 1) / CLK_NS;
	localparam int RST_CNT_W   = 10;
	localparam logic [RST_CNT_W-1:0] RST_CNT_TOP =
		RST_CNT_W'(RST_MIN_CYC);

	// ==========================================================
	// Serial frame layout, counted in bits already sampled
	localparam logic [4:0] BIT_DIR   = 5'h08;
	localparam logic [4:0] BIT_DATA  = 5'h10;
	localparam logic [4:0] BIT_RDATA = 5'h11;
	localparam logic [4:0] FRAME_LEN = 5'h18;

	// ==========================================================
	// Register map
	localparam int         NUM_REGS = 143;
	localparam logic [7:0] REG_LAST = 8'h8E;
	localparam logic [7:0] REG_RST  = 8'h00;

	// ==========================================================
	// Parallel bus styles
	localparam logic [1:0] BUS_ASYNC_SEP = 2'h0;
	localparam logic [1:0] BUS_ASYNC_DIR = 2'h1;
	localparam logic [1:0] BUS_SYNC_SEP  = 2'h2;
	localparam logic [1:0] BUS_SYNC_DIR  = 2'h3;

	// ==========================================================
	// Pin synchroniser
	localparam int         SYNC_W   = 27;
	localparam logic [SYNC_W-1:0] SYNC_RST = {SYNC_W{1'b1}};

	typedef enum logic {P_IDLE, P_ACK} hrap_pstate_type;

	typedef struct packed {
		logic                  sclk_q;
		logic                  cs_q;
		logic [4:0]            cnt;
		logic [7:0]            s_addr;
		logic                  dir;
		logic [7:0]            wdata;
		logic                  serial_out;
		logic                  sdo_oe;
		hrap_pstate_type       p_state;
		logic [7:0]            p_addr;
		logic [7:0]            p_dout;
		logic                  p_oe;
		logic                  ack_n;
		logic                  wr_pulse;
		logic [7:0]            wr_addr;
		logic [7:0]            wr_data;
		logic [RST_CNT_W-1:0]  rst_cnt;
		logic                  rf_clear;
		logic                  txen;
		logic                  irq_n;
	} hrap_state_type;

	localparam hrap_state_type ST_RST = '{sclk_q: 1'b1, cs_q: 1'b1,
		ack_n: 1'b1, irq_n: 1'b1, txen: 1'b1, p_state: P_IDLE,
		default: '0};

	typedef struct packed {
		logic [NUM_REGS-1:0][7:0] regs;
	} hrap_rf_type;

	localparam hrap_rf_type RF_RST = '{regs: {NUM_REGS{REG_RST}}};
endpackage

/* src/hrap_regfile.sv */
// Byte-wide register array behind the host port.
// Assumes one write port and one combinational read port.
`timescale 1ns/1ns
module hrap_regfile (
	input  wire logic       i_clk,     // System clock
	input  wire logic       i_sys_rst, // Async reset, high
	input  wire logic       i_clear,   // Restore defaults pulse
	input  wire logic       i_we,      // Write pulse
	input  wire logic [7:0] i_waddr,   // Write address
	input  wire logic [7:0] i_wdata,   // Write data
	input  wire logic [7:0] i_raddr,   // Read address
	output logic      [7:0] o_rdata    // Read data
);
	hrap_pkg::hrap_rf_type rf_ff;
	hrap_pkg::hrap_rf_type nxt_rf;

	// ==========================================================
	// Channel blocks 0x00-0x7F and globals up to 0x8E
	always_comb begin
		nxt_rf = rf_ff;
		if (i_clear) begin
			nxt_rf = hrap_pkg::RF_RST;
		end else if (i_we && i_waddr <= hrap_pkg::REG_LAST) begin
			nxt_rf.regs[i_waddr] = i_wdata;
		end
	end

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			rf_ff <= hrap_pkg::RF_RST;
		end else begin
			rf_ff <= nxt_rf;
		end
	end

	// Unmapped addresses read as zero
	assign o_rdata = (i_raddr <= hrap_pkg::REG_LAST) ?
		rf_ff.regs[i_raddr] : 8'h00;
endmodule

/* src/hrap_sync.sv */
// Two-flop synchroniser bank for pins entering the system clock.
// Assumes every bit is a slow level relative to the 10 ns clock.
`timescale 1ns/1ns
module hrap_sync #(
	parameter int W = 1
) (
	input  wire logic         i_clk,     // System clock
	input  wire logic         i_sys_rst, // Async reset, high
	input  wire logic [W-1:0] i_async,   // Raw pin levels
	output logic      [W-1:0] o_sync     // Synchronised levels
);
	logic [W-1:0] meta_ff;
	logic [W-1:0] sync_ff;

	// ==========================================================
	// One pair of flops per bit
	for (genvar b = 0; b < W; b++) begin : g_bit
		always_ff @(posedge i_clk or posedge i_sys_rst) begin
			if (i_sys_rst) begin
				meta_ff[b] <= 1'b1;
				sync_ff[b] <= 1'b1;
			end else begin
				meta_ff[b] <= i_async[b];
				sync_ff[b] <= meta_ff[b];
			end
		end
	end

	assign o_sync = sync_ff;
endmodule

/* src/hrap_top.sv */
// Host register access port: serial frame engine, parallel
// strobe engine, pin reset filter and register array.
// Assumes all pins but the alarm input are asynchronous and pass the sync bank.
//
// How it works
// - Port select low picks parallel bus; high picks serial port.
// - Reset pin low over ten microseconds restores register defaults.
// - A serial frame is 24 bits sampled on serial clock rises.
// - Serial write commits only after 24 bits, when chip select rises.
// - Clocks one to eight carry the address, least significant first.
// - Ninth bit picks direction: zero writes, one reads.
// - Bits ten through sixteen are ignored.
// - Clocks seventeen to twenty-four carry write data, LSB first.
// - Read data leaves on falling clocks 17 to 24, bit 0 first.
// - Bus type pins choose the parallel strobe protocol.
// - Parallel port uses eight address inputs and eight data lines.
// - Parallel accesses are served only while chip select is low.
// - Separate-strobe mode latches address on latch enable fall.
// - Read strobe low with select low starts a read.
// - Write strobe low with select low writes the data bus.
// - Acknowledge goes low when the access is done.
// - Direction mode latches address on address strobe fall.
// - Direction input high reads, low writes.
// - Data strobe low with select low starts the access.
// - Transmit-on low turns the line drivers off.
// - An interrupt output is offered besides register polling.
// - Channels hold sixteen addresses each; globals sit at 0x80-0x8E.
`timescale 1ns/1ns
module hrap_top (
	input  wire logic       i_clk,                   // 100 MHz
	input  wire logic       i_sys_rst,               // Async, high
	input  wire logic       i_reset_n,               // Reset pin
	input  wire logic       i_host_port_select,      // 1 serial
	input  wire logic [1:0] i_host_bus_type_select,  // Bus style
	input  wire logic       i_transmit_drive_on,     // Tx on pin
	input  wire logic       i_cs_n,                  // Chip select
	input  wire logic       i_sclk,                  // Serial clock
	input  wire logic       i_serial_in,             // Serial data
	input  wire logic       i_address_strobe,        // Latch enable
	input  wire logic       i_read_or_data_strobe_n, // Read or DS
	input  wire logic       i_write_or_dir,          // Write or R/W
	input  wire logic [7:0] i_addr,                  // Address bus
	input  wire logic [7:0] i_data,                  // Data bus in
	input  wire logic       i_alarm,                 // Core event
	output logic      [7:0] o_data,                  // Data bus out
	output logic            o_data_oe,               // Data enable
	output logic            o_serial_out,            // Serial out
	output logic            o_serial_out_oe,         // Serial enable
	output logic            o_transfer_ack_n,        // Completion
	output logic            o_tx_drivers_en,         // Line drivers
	output logic            o_irq_n,                 // Interrupt
	output logic            o_wr_pulse,              // Reg written
	output logic      [7:0] o_wr_addr,               // Its address
	output logic      [7:0] o_wr_data                // Its data
);
	hrap_pkg::hrap_state_type st_ff;
	hrap_pkg::hrap_state_type nxt_st;

	logic [hrap_pkg::SYNC_W-1:0] sync_out;
	logic       s_rst_n;
	logic       s_psel;
	logic [1:0] s_btype;
	logic       s_transmit_drive_on;
	logic       s_cs_n;
	logic       s_sclk;
	logic       s_sdi;
	logic       s_ale;
	logic       s_rds_n;
	logic       s_wrd;
	logic [7:0] s_addr_pin;
	logic [7:0] s_data_pin;
	logic [7:0] rf_rdata;
	logic [7:0] rf_raddr;
	logic       sclk_rise;
	logic       sclk_fall;
	logic       cs_rise;
	logic       dir_style;
	logic       par_req;
	logic       par_rd;
	logic       par_start;
	logic       ser_wr;
	logic       rd_bit;

	// ==========================================================
	// Pin synchronisers
	hrap_sync #(
		.W (hrap_pkg::SYNC_W)
	) u_sync (
		.i_clk     (i_clk),
		.i_sys_rst (i_sys_rst),
		.i_async   ({i_reset_n, i_host_port_select,
			i_host_bus_type_select, i_transmit_drive_on, i_cs_n,
			i_sclk, i_serial_in, i_address_strobe,
			i_read_or_data_strobe_n, i_write_or_dir, i_addr,
			i_data}),
		.o_sync    (sync_out)
	);

	assign {s_rst_n, s_psel, s_btype, s_transmit_drive_on, s_cs_n, s_sclk, s_sdi,
		s_ale, s_rds_n, s_wrd, s_addr_pin, s_data_pin} = sync_out;

	// ==========================================================
	// Register array
	assign rf_raddr = s_psel ? st_ff.s_addr : st_ff.p_addr;

	hrap_regfile u_regs (
		.i_clk     (i_clk),
		.i_sys_rst (i_sys_rst),
		.i_clear   (st_ff.rf_clear),
		.i_we      (st_ff.wr_pulse),
		.i_waddr   (st_ff.wr_addr),
		.i_wdata   (st_ff.wr_data),
		.i_raddr   (rf_raddr),
		.o_rdata   (rf_rdata)
	);

	// ==========================================================
	// Edge and request decode
	assign sclk_rise = s_sclk & ~st_ff.sclk_q;
	assign sclk_fall = ~s_sclk & st_ff.sclk_q;
	assign cs_rise   = s_cs_n & ~st_ff.cs_q;
	assign dir_style = (s_btype == hrap_pkg::BUS_ASYNC_DIR) ||
		(s_btype == hrap_pkg::BUS_SYNC_DIR);
	// Separate strobes: read wins if both are low together
	assign par_req = dir_style ? !s_rds_n :
		(!s_rds_n || !s_wrd);
	assign par_rd  = dir_style ? s_wrd : !s_rds_n;
	assign par_start = (st_ff.p_state == hrap_pkg::P_IDLE) &&
		!s_psel && !s_cs_n && par_req;
	assign ser_wr = s_psel && cs_rise && !st_ff.dir &&
		(st_ff.cnt == hrap_pkg::FRAME_LEN);
	assign rd_bit = rf_rdata[3'(st_ff.cnt - hrap_pkg::BIT_RDATA)];

	// ==========================================================
	// Next state
	always_comb begin
		nxt_st = st_ff;
		nxt_st.sclk_q   = s_sclk;
		nxt_st.cs_q     = s_cs_n;
		nxt_st.wr_pulse = 1'b0;
		nxt_st.rf_clear = 1'b0;
		nxt_st.txen     = s_transmit_drive_on;
		nxt_st.irq_n    = ~i_alarm;

		// Reset pin filter
		if (s_rst_n) begin
			nxt_st.rst_cnt = '0;
		end else if (st_ff.rst_cnt != hrap_pkg::RST_CNT_TOP) begin
			nxt_st.rst_cnt = st_ff.rst_cnt + 1'b1;
			nxt_st.rf_clear = (st_ff.rst_cnt ==
				hrap_pkg::RST_CNT_TOP - 1'b1);
		end

		// Serial frame
		if (s_cs_n) begin
			nxt_st.cnt    = 5'h00;
			nxt_st.sdo_oe = 1'b0;
		end else if (s_psel) begin
			if (sclk_rise && st_ff.cnt < hrap_pkg::FRAME_LEN) begin
				nxt_st.cnt = st_ff.cnt + 5'h01;
				if (st_ff.cnt < hrap_pkg::BIT_DIR) begin
					nxt_st.s_addr[st_ff.cnt[2:0]] = s_sdi;
				end else if (st_ff.cnt == hrap_pkg::BIT_DIR) begin
					nxt_st.dir = s_sdi;
				end else if (st_ff.cnt >= hrap_pkg::BIT_DATA) begin
					nxt_st.wdata[st_ff.cnt[2:0]] = s_sdi;
				end
				// Dummy bits fall through untouched
			end
			if (sclk_fall && st_ff.dir &&
				st_ff.cnt >= hrap_pkg::BIT_RDATA) begin
				nxt_st.serial_out    = rd_bit;
				nxt_st.sdo_oe = 1'b1;
			end
		end

		// Address latch is transparent while latch enable is high
		if (s_ale) begin
			nxt_st.p_addr = s_addr_pin;
		end

		// Parallel access
		unique case (st_ff.p_state)
			hrap_pkg::P_IDLE: begin
				if (par_start) begin
					nxt_st.p_state = hrap_pkg::P_ACK;
					nxt_st.ack_n   = 1'b0;
					if (par_rd) begin
						nxt_st.p_dout = rf_rdata;
						nxt_st.p_oe   = 1'b1;
					end else begin
						nxt_st.wr_pulse = 1'b1;
						nxt_st.wr_addr  = st_ff.p_addr;
						nxt_st.wr_data  = s_data_pin;
					end
				end
			end
			hrap_pkg::P_ACK: begin
				if (s_cs_n || !par_req) begin
					nxt_st.p_state = hrap_pkg::P_IDLE;
					nxt_st.ack_n   = 1'b1;
					nxt_st.p_oe    = 1'b0;
				end
			end
		endcase

		if (ser_wr) begin
			nxt_st.wr_pulse = 1'b1;
			nxt_st.wr_addr  = st_ff.s_addr;
			nxt_st.wr_data  = st_ff.wdata;
		end
	end

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			st_ff <= hrap_pkg::ST_RST;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ==========================================================
	// Outputs
	assign o_data           = st_ff.p_dout;
	assign o_data_oe        = st_ff.p_oe;
	assign o_serial_out     = st_ff.serial_out;
	assign o_serial_out_oe  = st_ff.sdo_oe;
	assign o_transfer_ack_n = st_ff.ack_n;
	assign o_tx_drivers_en  = st_ff.txen;
	assign o_irq_n          = st_ff.irq_n;
	assign o_wr_pulse       = st_ff.wr_pulse;
	assign o_wr_addr        = st_ff.wr_addr;
	assign o_wr_data        = st_ff.wr_data;

	// ==========================================================
	// Assertions
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);

	a_port_select: assert property (
		((s_psel && st_ff.p_state == hrap_pkg::P_IDLE) |=>
		st_ff.p_state == hrap_pkg::P_IDLE) and
		((!s_psel && cs_rise) |=> !o_wr_pulse))
		else $error("access taken on the wrong port");

	a_reset_hold: assert property (
		st_ff.rf_clear |->
		st_ff.rst_cnt == hrap_pkg::RST_CNT_TOP && $past(!s_rst_n))
		else $error("defaults restored without full reset hold");

	a_bit_count: assert property (
		(sclk_rise && !s_cs_n && s_psel &&
		st_ff.cnt < hrap_pkg::FRAME_LEN) |=>
		st_ff.cnt == $past(st_ff.cnt) + 5'h01)
		else $error("serial bit not counted");

	a_write_commit: assert property (
		ser_wr |=> st_ff.wr_pulse &&
		st_ff.wr_addr == $past(st_ff.s_addr) &&
		st_ff.wr_data == $past(st_ff.wdata))
		else $error("serial write not committed");

	a_addr_lsb: assert property (
		(sclk_rise && !s_cs_n && s_psel && st_ff.cnt == 5'h00) |=>
		st_ff.s_addr[0] == $past(s_sdi))
		else $error("first bit not address bit 0");

	a_dir_bit: assert property (
		(sclk_rise && !s_cs_n && s_psel &&
		st_ff.cnt == hrap_pkg::BIT_DIR) |=> st_ff.dir == $past(s_sdi))
		else $error("ninth bit not taken as direction");

	a_read_bit: assert property (
		(sclk_fall && !s_cs_n && s_psel && st_ff.dir &&
		st_ff.cnt >= hrap_pkg::BIT_RDATA) |=>
		st_ff.serial_out == $past(rd_bit) && st_ff.sdo_oe)
		else $error("serial read bit wrong");

	a_cs_gate: assert property (
		(!s_psel && s_cs_n && st_ff.p_state == hrap_pkg::P_IDLE) |=>
		o_transfer_ack_n && !o_data_oe && !o_wr_pulse)
		else $error("parallel access without chip select");

	a_ack_done: assert property (
		par_start |=> !o_transfer_ack_n ##1
		(!o_transfer_ack_n || $past(s_cs_n || !par_req)))
		else $error("acknowledge not given");

	a_dir_read: assert property (
		(par_start && dir_style) |=> o_data_oe == $past(s_wrd))
		else $error("direction input misread");

	a_tx_off: assert property (
		!s_transmit_drive_on |=> !o_tx_drivers_en)
		else $error("drivers stay on with transmit off");

	a_cnt_clear: assert property (
		s_cs_n |=> st_ff.cnt == 5'h00 && !o_serial_out_oe)
		else $error("bit counter not cleared");

	a_short_drop: assert property (
		(s_psel && cs_rise && st_ff.cnt != hrap_pkg::FRAME_LEN) |=>
		!st_ff.wr_pulse)
		else $error("short frame wrote a register");

	a_dummy_skip: assert property (
		(sclk_rise && !s_cs_n && s_psel &&
		st_ff.cnt > hrap_pkg::BIT_DIR &&
		st_ff.cnt < hrap_pkg::BIT_DATA) |=>
		$stable(st_ff.s_addr) && $stable(st_ff.dir) &&
		$stable(st_ff.wdata))
		else $error("dummy bit changed the frame");

	a_data_lsb: assert property (
		(sclk_rise && !s_cs_n && s_psel &&
		st_ff.cnt == hrap_pkg::BIT_DATA) |=>
		st_ff.wdata[0] == $past(s_sdi))
		else $error("first data bit misplaced");

	a_latch_hold: assert property (
		!s_ale |=> st_ff.p_addr == $past(st_ff.p_addr))
		else $error("address moved with latch closed");

	a_par_write: assert property (
		(par_start && !par_rd) |=> o_wr_pulse &&
		o_wr_addr == $past(st_ff.p_addr) &&
		o_wr_data == $past(s_data_pin))
		else $error("parallel write lost");

	a_par_read: assert property (
		(par_start && par_rd) |=> o_data_oe &&
		o_data == $past(rf_rdata))
		else $error("parallel read data wrong");

	a_sdo_window: assert property (
		o_serial_out_oe |->
		st_ff.dir && st_ff.cnt >= hrap_pkg::BIT_RDATA)
		else $error("serial out driven outside read data");

	a_clear_pulse: assert property (
		st_ff.rf_clear |=> !st_ff.rf_clear)
		else $error("defaults restored more than once");

	c_ser_write: cover property (ser_wr);
	c_ser_read: cover property ($rose(o_serial_out_oe));
	c_par_read: cover property (par_start && par_rd);
	c_par_write: cover property (par_start && !par_rd);
endmodule

/* test/hrap_host_model.sv */
// Host processor model driving the serial and parallel host ports.
// Assumes the caller picks port select and bus style beforehand.
`timescale 1ns/1ns
module hrap_host_model (
	input  wire logic       i_clk,     // System clock
	input  wire logic [7:0] i_rdata,   // Device data out
	input  wire logic       i_rdata_oe,// Device data enable
	input  wire logic       i_so,      // Serial out
	input  wire logic       i_so_oe,   // Serial out enable
	input  wire logic       i_ack_n,   // Completion
	output logic            o_cs_n,    // Chip select
	output logic            o_sclk,    // Serial clock
	output logic            o_sdi,     // Serial data
	output logic            o_ale,     // Latch enable
	output logic            o_rds_n,   // Read or data strobe
	output logic            o_wrd,     // Write strobe or direction
	output logic      [7:0] o_addr,    // Address bus
	output wire logic [7:0] o_data     // Data bus level
);
	logic [7:0] hd;
	logic       hd_oe;
	logic [7:0] last;
	bit         ale_tied;

	// Released bus shows the inverse of the last level
	assign o_data = hd_oe ? hd : (i_rdata_oe ? i_rdata : ~last);
	always @(posedge i_clk) last <= o_data;

	initial begin
		o_cs_n = 1'b1; o_sclk = 1'b0; o_sdi = 1'b0; o_ale = 1'b0;
		o_rds_n = 1'b1; o_wrd = 1'b1; o_addr = 8'h00;
		hd = 8'h00; hd_oe = 1'b0; last = 8'h00; ale_tied = 1'b0;
	end

	// Host without a latch signal keeps latch enable high
	task automatic tie_ale(input bit t);
		ale_tied = t;
		o_ale = t;
	endtask

	// ==========================================================
	// Serial frame, LSB first; one clock pulse with chip select high comes before each frame
	task automatic ser_bits(input logic [23:0] f, input int nb,
		output logic [7:0] rd, output bit oe_ok);
		rd = 8'h00;
		oe_ok = 1'b1;
		o_cs_n = 1'b1;
		#63 o_sclk = 1'b1;
		#62 o_sclk = 1'b0;
		#63 o_cs_n = 1'b0;
		#63;
		for (int k = 0; k < nb; k++) begin
			o_sdi = f[k];
			#23 o_sclk = 1'b1;
			#62 o_sclk = 1'b0;
			#40;
			if (k >= 16) rd[k-16] = i_so;
			if (i_so_oe !== (f[8] && k >= 16)) oe_ok = 1'b0;
		end
	endtask

	task automatic ser_end();
		#63 o_cs_n = 1'b1;
		o_sdi = ~o_sdi;
		repeat (10) @(negedge i_clk);
	endtask

	// ==========================================================
	// Parallel access; address pins invert after the latch closes unless latch enable is tied high
	task automatic par(input bit sel, input bit dirm, input bit rw,
		input logic [7:0] a, input logic [7:0] wd,
		output logic [7:0] rd, output bit ack, output int lat);
		rd = 8'h00;
		ack = 1'b0;
		lat = 0;
		@(negedge i_clk);
		o_cs_n = ~sel; o_addr = a; o_ale = 1'b1;
		repeat (4) @(negedge i_clk);
		o_ale = ale_tied;
		repeat (2) @(negedge i_clk);
		o_addr = ale_tied ? a : ~a; hd = wd; hd_oe = ~rw;
		if (dirm) o_wrd = rw;
		repeat (4) @(negedge i_clk);
		if (dirm || rw) o_rds_n = 1'b0;
		else o_wrd = 1'b0;
		for (int n = 1; n <= 20; n++) begin
			@(posedge i_clk);
			if (i_ack_n === 1'b0) begin
				// Ack counts only with the data bus turned the right way
				ack = (i_rdata_oe === rw); lat = n; rd = i_rdata; break;
			end
		end
		@(negedge i_clk);
		o_rds_n = 1'b1; o_wrd = 1'b1;
		for (int n = 0; n < 20 && ack; n++) begin
			@(posedge i_clk);
			if (i_ack_n === 1'b1) break;
		end
		@(negedge i_clk);
		o_cs_n = 1'b1; hd_oe = 1'b0;
		repeat (4) @(negedge i_clk);
	endtask
endmodule

/* test/test_host_register_access_port.sv */
// Self-checking bench for the host register access port.
// Assumes the host model drives the bus and serial pins; the bench drives reset and mode pins.
`timescale 1ns/1ns
module test_host_register_access_port;
	logic       i_clk, i_sys_rst, i_reset_n, i_host_port_select;
	logic [1:0] i_host_bus_type_select;
	logic       i_transmit_drive_on, i_alarm;
	logic       cs_n, sclk, serial_in, ale, rds_n, wrd;
	logic [7:0] addr, o_data, o_wr_addr, o_wr_data, wa, wd, r;
	wire  [7:0] bus;
	logic       o_data_oe, o_serial_out, o_serial_out_oe;
	logic       o_transfer_ack_n, o_tx_drivers_en, o_irq_n, o_wr_pulse;
	int         num_errors, n_compared, wr_cnt, c0, lat;
	bit         ok, ack;

	hrap_top dut_u (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
		.i_reset_n(i_reset_n), .i_host_port_select(i_host_port_select),
		.i_host_bus_type_select(i_host_bus_type_select),
		.i_transmit_drive_on(i_transmit_drive_on), .i_cs_n(cs_n),
		.i_sclk(sclk), .i_serial_in(serial_in), .i_address_strobe(ale),
		.i_read_or_data_strobe_n(rds_n), .i_write_or_dir(wrd),
		.i_addr(addr), .i_data(bus), .i_alarm(i_alarm),
		.o_data(o_data), .o_data_oe(o_data_oe),
		.o_serial_out(o_serial_out), .o_serial_out_oe(o_serial_out_oe),
		.o_transfer_ack_n(o_transfer_ack_n),
		.o_tx_drivers_en(o_tx_drivers_en), .o_irq_n(o_irq_n),
		.o_wr_pulse(o_wr_pulse), .o_wr_addr(o_wr_addr),
		.o_wr_data(o_wr_data));

	hrap_host_model host_u (.i_clk(i_clk), .i_rdata(o_data),
		.i_rdata_oe(o_data_oe), .i_so(o_serial_out),
		.i_so_oe(o_serial_out_oe), .i_ack_n(o_transfer_ack_n),
		.o_cs_n(cs_n), .o_sclk(sclk), .o_sdi(serial_in), .o_ale(ale),
		.o_rds_n(rds_n), .o_wrd(wrd), .o_addr(addr), .o_data(bus));

	initial begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end

	always @(posedge i_clk)
		if (o_wr_pulse === 1'b1) begin
			wr_cnt++; wa = o_wr_addr; wd = o_wr_data;
		end

	// ==========================================================
	// Checking and closing
	task automatic chk(input bit good, input string msg);
		n_compared++;
		if (!good) begin
			num_errors++;
			$display("CHECK FAILED at %0t: %s", $time, msg);
		end
	endtask

	task automatic end_sim();
		$display("compared %0d, mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	task automatic mode(input bit ser, input logic [1:0] bt);
		@(negedge i_clk);
		i_host_port_select = ser; i_host_bus_type_select = bt;
		repeat (6) @(negedge i_clk);
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_serial();
		mode(1'b1, 2'h0);
		c0 = wr_cnt;
		host_u.ser_bits({8'hA5, 7'h55, 1'b0, 8'h8E}, 24, r, ok);
		repeat (10) @(negedge i_clk);
		chk(wr_cnt == c0, "write before select rise");
		host_u.ser_end();
		chk(wr_cnt == c0 + 1 && wa === 8'h8E && wd === 8'hA5, "s write");
		chk(ok, "serial out driven in write");
		c0 = wr_cnt;
		host_u.ser_bits({8'hFF, 7'h2A, 1'b1, 8'h8E}, 24, r, ok);
		host_u.ser_end();
		chk(r === 8'hA5 && ok, "serial read");
		chk(wr_cnt == c0, "read frame wrote");
		chk(o_serial_out_oe === 1'b0, "serial out kept");
		$display("test serial done");
	endtask

	task automatic t_short();
		c0 = wr_cnt;
		host_u.ser_bits({8'h77, 7'h00, 1'b0, 8'h01}, 23, r, ok);
		host_u.ser_end();
		chk(wr_cnt == c0, "short frame wrote");
		host_u.ser_bits({8'h5A, 7'h7F, 1'b0, 8'h02}, 24, r, ok);
		host_u.ser_end();
		chk(wr_cnt == c0 + 1 && wa === 8'h02, "frame after short");
		host_u.ser_bits({8'h00, 7'h00, 1'b1, 8'h01}, 24, r, ok);
		host_u.ser_end();
		chk(r === 8'h00, "short frame changed reg");
		$display("test short frame done");
	endtask

	task automatic t_par();
		logic [7:0] a, d;
		for (int m = 0; m < 4; m++) begin
			a = 8'h70 + 8'(m);
			d = 8'hC0 | 8'(m);
			mode(1'b0, 2'(m));
			c0 = wr_cnt;
			host_u.par(1'b1, m[0], 1'b0, a, d, r, ack, lat);
			chk(ack && lat >= 3 && lat <= 5, "write ack");
			chk(wr_cnt == c0 + 1 && wa === a && wd === d, "p write");
			host_u.par(1'b1, m[0], 1'b1, a, 8'h00, r, ack, lat);
			chk(ack && lat >= 3 && lat <= 5 && r === d, "p read");
		end
		$display("test parallel done");
	endtask

	task automatic t_cs_map();
		mode(1'b0, 2'h0);
		c0 = wr_cnt;
		host_u.par(1'b0, 1'b0, 1'b0, 8'h70, 8'h11, r, ack, lat);
		chk(!ack && wr_cnt == c0, "write without select");
		host_u.par(1'b0, 1'b0, 1'b1, 8'h70, 8'h00, r, ack, lat);
		chk(!ack, "read without select");
		host_u.par(1'b1, 1'b0, 1'b0, 8'h90, 8'h33, r, ack, lat);
		host_u.par(1'b1, 1'b0, 1'b1, 8'h90, 8'h00, r, ack, lat);
		chk(ack && r === 8'h00, "unmapped read");
		host_u.par(1'b1, 1'b0, 1'b1, 8'h8E, 8'h00, r, ack, lat);
		chk(ack && r === 8'hA5, "last global reg");
		host_u.tie_ale(1'b1);
		host_u.par(1'b1, 1'b0, 1'b0, 8'h74, 8'h3C, r, ack, lat);
		host_u.par(1'b1, 1'b0, 1'b1, 8'h74, 8'h00, r, ack, lat);
		chk(ack && r === 8'h3C && wa === 8'h74, "tied latch");
		host_u.tie_ale(1'b0);
		c0 = wr_cnt;
		host_u.ser_bits({8'h99, 7'h00, 1'b0, 8'h03}, 24, r, ok);
		host_u.ser_end();
		host_u.par(1'b1, 1'b0, 1'b1, 8'h03, 8'h00, r, ack, lat);
		chk(wr_cnt == c0 && r === 8'h00, "serial used in par mode");
		$display("test select and map done");
	endtask

	task automatic t_reset();
		@(negedge i_clk) i_reset_n = 1'b0;
		repeat (500) @(negedge i_clk);
		i_reset_n = 1'b1;
		repeat (6) @(negedge i_clk);
		host_u.par(1'b1, 1'b0, 1'b1, 8'h8E, 8'h00, r, ack, lat);
		chk(r === 8'hA5, "short reset cleared");
		i_reset_n = 1'b0;
		repeat (1010) @(negedge i_clk);
		i_reset_n = 1'b1;
		repeat (6) @(negedge i_clk);
		host_u.par(1'b1, 1'b0, 1'b1, 8'h8E, 8'h00, r, ack, lat);
		chk(ack && r === 8'h00, "reset kept value");
		$display("test reset pin done");
	endtask

	task automatic t_pins();
		@(negedge i_clk) i_transmit_drive_on = 1'b0;
		repeat (6) @(negedge i_clk);
		chk(o_tx_drivers_en === 1'b0, "drivers on");
		i_transmit_drive_on = 1'b1; i_alarm = 1'b1;
		repeat (6) @(negedge i_clk);
		chk(o_tx_drivers_en === 1'b1 && o_irq_n === 1'b0, "pins");
		i_alarm = 1'b0;
		repeat (3) @(negedge i_clk);
		chk(o_irq_n === 1'b1, "interrupt stuck");
		$display("test pins done");
	endtask

	initial begin
		#200000;
		num_errors++;
		$display("CHECK FAILED at %0t: watchdog", $time);
		end_sim();
	end

	initial begin
		i_sys_rst = 1'b1; i_reset_n = 1'b1; i_host_port_select = 1'b1;
		i_host_bus_type_select = 2'h0; i_transmit_drive_on = 1'b1;
		i_alarm = 1'b0;
		num_errors = 0; n_compared = 0; wr_cnt = 0;
		repeat (10) @(negedge i_clk);
		i_sys_rst = 1'b0;
		repeat (6) @(negedge i_clk);
		t_serial();
		t_short();
		t_par();
		t_cs_map();
		t_reset();
		t_pins();
		end_sim();
	end
endmodule
